// File: design/mmra_mem.sv
// one write port, one read port word memory with registered read data
// assumes both ports on one clock; contents are not reset
`timescale 1ns/1ns
module mmra_mem #(
  parameter int W  = 32,
  parameter int D  = 128000,
  parameter int AW = 17
) (
  input  wire logic          i_clk_sys, // system clock
  input  wire logic          i_rst_n,   // async reset, active low
  input  wire logic          i_we,      // write strobe
  input  wire logic [AW-1:0] i_waddr,   // write address
  input  wire logic [W-1:0]  i_wdata,   // write data
  input  wire logic          i_re,      // read strobe
  input  wire logic [AW-1:0] i_raddr,   // read address
  output logic      [W-1:0]  o_rdata    // read data, one cycle after i_re
);
  logic [W-1:0] mem [D];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= '0;
    end
    else if (i_re)
    begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// File: design/mmra_top.sv
// mirror memory and reset array: ddr link loader, load cells, displayed cells, reset groups
// assumes link pins are asynchronous to i_clk_sys and data changes midway between link edges
`timescale 1ns/1ns
module mmra_top
  import mmra_pkg::*;
(
  input  wire logic                         i_clk_sys,                // system clock, 10 MHz
  input  wire logic                         i_rst_n,                  // async reset, active low
  input  wire logic                         i_lnk_clk,                // link clock pin
  input  wire logic                         i_lnk_frame,              // link frame, high during a load
  input  wire logic [mmra_pkg::LNK_W-1:0]   i_lnk_data,               // link data pins
  output logic                              o_lnk_ready,              // buffer has room
  input  wire logic                         i_rst_req,                // pulse request pin, rising edge
  input  wire logic                         i_rst_all,                // request covers all groups
  input  wire logic [mmra_pkg::GRP_W-1:0]   i_rst_group,              // group to pulse
  output logic                              o_rst_busy,               // pulse sequence running
  output logic      [mmra_pkg::GROUPS-1:0]  o_mirror_reset_line,      // per group reset pulse
  input  wire logic                         i_qry_req,                // shown-state query strobe
  input  wire logic [mmra_pkg::ROW_W-1:0]   i_qry_row,                // row incl. border band
  input  wire logic [mmra_pkg::COL_W-1:0]   i_qry_col,                // column incl. border band
  output logic                              o_qry_valid,              // query answer pulse
  output logic                              o_qry_q,                  // shown cell value
  output logic                              o_cell_complement_output  // inverse of shown value
);
  import mmra_pkg::*;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [ADDR_W-1:0] grp_base(input logic [GRP_W-1:0] g);
    grp_base = ADDR_W'(g * GROUP_WORDS);
  endfunction
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic             lk_s1_r, lk_s2_r, lk_s3_r;
  logic             fr_s1_r, fr_s2_r;
  logic [LNK_W-1:0] dt_s1_r, dt_s2_r;
  logic             rq_s1_r, rq_s2_r, rq_s3_r;
  logic             al_s1_r, al_s2_r;
  logic [GRP_W-1:0] gp_s1_r, gp_s2_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      {lk_s1_r, lk_s2_r, lk_s3_r} <= 3'h0;
      {fr_s1_r, fr_s2_r}          <= 2'h0;
      {dt_s1_r, dt_s2_r}          <= '0;
      {rq_s1_r, rq_s2_r, rq_s3_r} <= 3'h0;
      {al_s1_r, al_s2_r}          <= 2'h0;
      {gp_s1_r, gp_s2_r}          <= '0;
    end
    else
    begin
      {lk_s3_r, lk_s2_r, lk_s1_r} <= {lk_s2_r, lk_s1_r, i_lnk_clk};
      {fr_s2_r, fr_s1_r}          <= {fr_s1_r, i_lnk_frame};
      {dt_s2_r, dt_s1_r}          <= {dt_s1_r, i_lnk_data};
      {rq_s3_r, rq_s2_r, rq_s1_r} <= {rq_s2_r, rq_s1_r, i_rst_req};
      {al_s2_r, al_s1_r}          <= {al_s1_r, i_rst_all};
      {gp_s2_r, gp_s1_r}          <= {gp_s1_r, i_rst_group};
    end
  end
  // ****************************************
  // ddr capture and word pairing
  // ****************************************
  logic              lnk_edge;
  logic              half_r, hdr_done_r;
  logic [LNK_W-1:0]  low_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic              cap_push;
  logic [WORD_W-1:0] cap_word;
  logic [1:0]        f_cnt_r;
  assign lnk_edge = lk_s2_r ^ lk_s3_r;
  assign cap_word = {dt_s2_r, low_r};
  assign cap_push = fr_s2_r && lnk_edge && half_r && hdr_done_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      half_r     <= 1'b0;
      hdr_done_r <= 1'b0;
      low_r      <= '0;
      wr_addr_r  <= '0;
    end
    else if (!fr_s2_r)
    begin
      half_r     <= 1'b0;
      hdr_done_r <= 1'b0;
    end
    else if (lnk_edge)
    begin
      half_r <= !half_r;
      if (!half_r)
      begin
        low_r <= dt_s2_r;
      end
      else if (!hdr_done_r)
      begin
        // first word of a frame sets where the load starts, so partial loads are possible
        wr_addr_r  <= cap_word[ADDR_W-1:0];
        hdr_done_r <= 1'b1;
      end
      else if (f_cnt_r != 2'h2)
      begin
        wr_addr_r <= wr_addr_r + 1'b1;
      end
    end
  end
  // ****************************************
  // two-entry buffer
  // ****************************************
  mmra_state_e       st_r;
  logic [FIFO_W-1:0] f_mem_r [2];
  logic              f_wp_r, f_rp_r;
  logic              f_push, f_pop;
  logic [FIFO_W-1:0] f_head;
  assign f_push      = cap_push && (f_cnt_r != 2'h2);
  // draining stalls while a pulse sequence runs: copy, flush and pulse
  assign f_pop       = (f_cnt_r != 2'h0) && (st_r == MMRA_IDLE);
  assign f_head      = f_mem_r[f_rp_r];
  assign o_lnk_ready = (f_cnt_r != 2'h2);
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      f_wp_r     <= 1'b0;
      f_rp_r     <= 1'b0;
      f_cnt_r    <= 2'h0;
      f_mem_r    <= '{default: '0};
    end
    else
    begin
      if (f_push)
      begin
        f_mem_r[f_wp_r] <= {wr_addr_r, cap_word};
        f_wp_r          <= !f_wp_r;
      end
      if (f_pop)
      begin
        f_rp_r <= !f_rp_r;
      end
      f_cnt_r <= f_cnt_r + {1'b0, f_push} - {1'b0, f_pop};
    end
  end
  // ****************************************
  // load cells and displayed cells
  // ****************************************
  logic              ld_we;
  logic [ADDR_W-1:0] cp_addr_r, cp_end_r, cp_waddr_r, q_addr;
  logic              cp_re, cp_wv_r;
  logic [WORD_W-1:0] ld_rdata, sh_rdata;
  assign ld_we = f_pop && (f_head[FIFO_W-1 -: ADDR_W] < ADDR_W'(DEPTH));
  assign cp_re = (st_r == MMRA_COPY);
  mmra_mem #(.W(WORD_W), .D(DEPTH), .AW(ADDR_W)) u_load (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_we      (ld_we),
    .i_waddr   (f_head[FIFO_W-1 -: ADDR_W]),
    .i_wdata   (f_head[WORD_W-1:0]),
    .i_re      (cp_re),
    .i_raddr   (cp_addr_r),
    .o_rdata   (ld_rdata)
  );
  // shown cells are written only by the pulse sequence, so loading never disturbs them
  mmra_mem #(.W(WORD_W), .D(DEPTH), .AW(ADDR_W)) u_shown (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_we      (cp_wv_r),
    .i_waddr   (cp_waddr_r),
    .i_wdata   (ld_rdata),
    .i_re      (i_qry_req),
    .i_raddr   (q_addr),
    .o_rdata   (sh_rdata)
  );
  // ****************************************
  // reset group sequencer
  // ****************************************
  logic              rq_rise;
  logic              all_r;
  logic [GRP_W-1:0]  grp_r;
  logic [PC_W-1:0]   pc_r;
  assign rq_rise    = rq_s2_r && !rq_s3_r;
  assign o_rst_busy = (st_r != MMRA_IDLE);
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r       <= MMRA_IDLE;
      all_r      <= 1'b0;
      grp_r      <= '0;
      cp_addr_r  <= '0;
      cp_end_r   <= '0;
      cp_waddr_r <= '0;
      cp_wv_r    <= 1'b0;
      pc_r       <= '0;
      o_mirror_reset_line <= '0;
    end
    else
    begin
      cp_wv_r    <= cp_re;
      cp_waddr_r <= cp_addr_r;
      unique case (st_r)
        MMRA_IDLE:
        begin
          // requests during a running sequence are ignored
          if (rq_rise)
          begin
            all_r     <= al_s2_r;
            grp_r     <= gp_s2_r;
            cp_addr_r <= al_s2_r ? '0 : grp_base(gp_s2_r);
            cp_end_r  <= al_s2_r ? ADDR_W'(DEPTH - 1) : ADDR_W'(grp_base(gp_s2_r) + GROUP_WORDS - 1);
            st_r      <= MMRA_COPY;
          end
        end
        MMRA_COPY:
        begin
          // the whole group is re-applied, written or not
          if (cp_addr_r == cp_end_r)
          begin
            st_r <= MMRA_FLUSH;
          end
          else
          begin
            cp_addr_r <= cp_addr_r + 1'b1;
          end
        end
        MMRA_FLUSH:
        begin
          pc_r                <= '0;
          o_mirror_reset_line <= all_r ? '1 : (GROUPS'(1) << grp_r);
          st_r                <= MMRA_PULSE;
        end
        MMRA_PULSE:
        begin
          pc_r <= pc_r + 1'b1;
          if (pc_r == PC_W'(RST_PULSE_CYC - 1))
          begin
            o_mirror_reset_line <= '0;
            st_r                <= MMRA_IDLE;
          end
        end
      endcase
    end
  end
  // ****************************************
  // shown-state query
  // ****************************************
  logic [ROW_W-1:0] q_row;
  logic [COL_W-1:0] q_col;
  logic             q_act, q_act_r, q_v_r;
  logic [BIT_W-1:0] q_bit_r;
  assign q_act  = (i_qry_row >= BORDER_R) && (i_qry_row < ROW_END) &&
                  (i_qry_col >= BORDER_C) && (i_qry_col < COL_END);
  assign q_row  = i_qry_row - BORDER_R;
  assign q_col  = i_qry_col - BORDER_C;
  assign q_addr = ADDR_W'(q_row * WORDS_PER_ROW + q_col[COL_W-1:BIT_W]);
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q_v_r                    <= 1'b0;
      q_act_r                  <= 1'b0;
      q_bit_r                  <= '0;
      o_qry_valid              <= 1'b0;
      o_qry_q                  <= 1'b0;
      o_cell_complement_output <= 1'b1;
    end
    else
    begin
      q_v_r       <= i_qry_req;
      q_act_r     <= q_act;
      q_bit_r     <= q_col[BIT_W-1:0];
      o_qry_valid <= q_v_r;
      if (q_v_r)
      begin
        // border band cells always land off, one means on tilt
        o_qry_q                  <= q_act_r && sh_rdata[q_bit_r];
        o_cell_complement_output <= !(q_act_r && sh_rdata[q_bit_r]);
      end
    end
  end
endmodule

// File: inc/mmra_pkg.sv
// constants shared by the mirror memory and reset array design
// assumes a 10 MHz system clock; geometry is fixed at the documented array size
package mmra_pkg;
  localparam int          CLK_NS         = 100;
  localparam int          COLS           = 2560;
  localparam int          ROWS           = 1600;
  localparam int          WORD_W         = 32;
  localparam int          WORDS_PER_ROW  = COLS / WORD_W;
  localparam int          DEPTH          = COLS * ROWS / WORD_W;
  localparam int          ADDR_W         = 17;
  localparam int          LNK_W          = 16;
  localparam int          GROUPS         = 16;
  localparam int          GRP_W          = 4;
  localparam int          ROWS_PER_GROUP = ROWS / GROUPS;
  localparam int          GROUP_WORDS    = ROWS_PER_GROUP * WORDS_PER_ROW;
  localparam int          ROW_W          = 11;
  localparam int          COL_W          = 12;
  localparam int          BIT_W          = 5;
  localparam int          CW_W           = 7;
  localparam logic [10:0] BORDER_R       = 11'h00e;
  localparam logic [11:0] BORDER_C       = 12'h00e;
  localparam logic [10:0] ROW_END        = 11'h64e;
  localparam logic [11:0] COL_END        = 12'ha0e;
  localparam int          RST_PULSE_NS   = 2000;
  localparam int          RST_PULSE_CYC  = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PC_W           = 8;
  localparam int          FIFO_W         = ADDR_W + WORD_W;

  typedef enum logic [3:0] {
    MMRA_IDLE  = 4'b0001,
    MMRA_COPY  = 4'b0010,
    MMRA_FLUSH = 4'b0100,
    MMRA_PULSE = 4'b1000
  } mmra_state_e;
endpackage

// File: verif/mmra_ctl_model.sv
// controller model: frames loads onto the ddr link
// assumes an 800 ns link period; the link clock runs only inside frames
`timescale 1ns/1ns
module mmra_ctl_model
  import mmra_pkg::*;
(
  output logic                        o_lnk_clk,   // link clock
  output logic                        o_lnk_frame, // load frame
  output logic [mmra_pkg::LNK_W-1:0]  o_lnk_data,  // link data
  input  wire logic                   i_lnk_ready  // buffer room
);
  localparam int HALF_NS = 400;
  initial
  begin
    o_lnk_clk   = 1'b0;
    o_lnk_frame = 1'b0;
    o_lnk_data  = 16'h0000;
  end
  // data moves midway between edges, leaving margin on both sides
  task automatic put_half(input logic [15:0] h);
    o_lnk_data = h;
    #(HALF_NS / 2);
    o_lnk_clk = ~o_lnk_clk;
    #(HALF_NS / 2);
  endtask
  task automatic put_word(input logic [31:0] w);
    put_half(w[15:0]);
    put_half(w[31:16]);
    #HALF_NS;
  endtask
  // waits for room before each data word, not the address word, so a stall loses nothing
  task automatic load(input logic [31:0] addr, input logic [31:0] words[$]);
    o_lnk_frame = 1'b1;
    #(HALF_NS / 2);
    put_word(addr);
    foreach (words[i])
    begin
      // a released stall lands on a clock edge, so step off it before moving the pins
      if (i_lnk_ready !== 1'b1)
      begin
        wait (i_lnk_ready === 1'b1);
        #(HALF_NS / 8);
      end
      put_word(words[i]);
    end
    o_lnk_frame = 1'b0;
    o_lnk_data  = ~o_lnk_data;
  endtask
endmodule

// File: verif/mmra_props.sv
// assertions on the mmra_top ports
// assumes one clock domain; bound to every mmra_top instance
`timescale 1ns/1ns
module mmra_props
  import mmra_pkg::*;
(
  input wire logic                          i_clk_sys,               // clock
  input wire logic                          i_rst_n,                 // reset
  input wire logic                          i_qry_req,               // query strobe
  input wire logic [mmra_pkg::ROW_W-1:0]    i_qry_row,               // query row
  input wire logic                          o_rst_busy,              // busy
  input wire logic [mmra_pkg::GROUPS-1:0]   o_mirror_reset_line,     // reset lines
  input wire logic                          o_qry_valid,             // answer pulse
  input wire logic                          o_qry_q,                 // shown value
  input wire logic                          o_cell_complement_output // inverse
);
  logic       line_on;
  logic [7:0] hi_cnt_r;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  assign line_on = |o_mirror_reset_line;
  // the pulse is too long for a repetition, so its width is counted here
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
      hi_cnt_r <= 8'h00;
    else
      hi_cnt_r <= line_on ? hi_cnt_r + 8'h01 : 8'h00;
  sequence s_ask;
    i_qry_req;
  endsequence
  sequence s_border_ask;
    i_qry_req && (i_qry_row < BORDER_R || i_qry_row >= ROW_END);
  endsequence
  chk_qry_latency: assert property (s_ask |-> ##2 o_qry_valid) else $error("query answer late");
  chk_qry_origin: assert property (o_qry_valid |-> $past(i_qry_req, 2)) else $error("answer without query");
  chk_cmpl_inverse: assert property (o_cell_complement_output != o_qry_q) else $error("complement wrong");
  chk_border_off: assert property (s_border_ask |-> ##2 (!o_qry_q && o_cell_complement_output))
    else $error("border cell shown on");
  chk_shown_hold: assert property (!o_qry_valid |-> $stable(o_qry_q)) else $error("shown value moved");
  chk_line_width: assert property ($fell(line_on) |-> hi_cnt_r == 8'(RST_PULSE_CYC)) else $error("pulse width wrong");
  chk_line_short: assert property (line_on |-> hi_cnt_r < 8'(RST_PULSE_CYC)) else $error("pulse too long");
  chk_line_busy: assert property (line_on |-> o_rst_busy) else $error("pulse while idle");
  chk_line_group: assert property (line_on |-> ($onehot(o_mirror_reset_line) || &o_mirror_reset_line))
    else $error("bad group pattern");
  chk_line_steady: assert property (line_on && $past(line_on) |-> $stable(o_mirror_reset_line))
    else $error("group changed mid pulse");
  chk_busy_end: assert property ($fell(line_on) |-> $fell(o_rst_busy)) else $error("busy end wrong");
endmodule

bind mmra_top mmra_props u_props (.i_clk_sys, .i_rst_n, .i_qry_req, .i_qry_row, .o_rst_busy,
  .o_mirror_reset_line, .o_qry_valid, .o_qry_q, .o_cell_complement_output);

// File: verif/mmra_top_tb.sv
// self-checking bench for mmra_top with the controller model
// assumes 10 MHz clock, 800 ns link; group pulses only, an all-array copy would be too long
`timescale 1ns/1ns
module mmra_top_tb;
  import mmra_pkg::*;
  typedef struct packed {logic [10:0] row; logic [11:0] col; logic q;} mmra_row_s;
  localparam logic [31:0] W0 = 32'hf00f_a5c3;
  localparam logic [31:0] W1 = 32'h8000_0001;
  localparam logic [31:0] W2 = 32'h1234_5678;
  localparam logic [31:0] W3 = 32'h0000_ffff;
  logic        clk, rst_n, lnk_clk, lnk_frame, lnk_ready, rst_req, rst_all, rst_busy;
  logic        qry_req, qry_valid, qry_q, qry_cmp;
  logic [15:0] lnk_data, line;
  logic [3:0]  rst_group;
  logic [10:0] qry_row;
  logic [11:0] qry_col;
  int          mismatches, num_checks, cycles;
  mmra_row_s   cases [12] = '{'{11'h00e, 12'h00e, 1'b1}, '{11'h00e, 12'h010, 1'b0}, '{11'h00e, 12'h015, 1'b1},
    '{11'h00e, 12'h02d, 1'b1}, '{11'h00e, 12'h029, 1'b0}, '{11'h00e, 12'h02e, 1'b1}, '{11'h00e, 12'h02f, 1'b0},
    '{11'h00e, 12'h04d, 1'b1}, '{11'h000, 12'h014, 1'b0}, '{11'h64e, 12'h014, 1'b0}, '{11'h014, 12'h000, 1'b0},
    '{11'h014, 12'ha0e, 1'b0}};
  mmra_top DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_lnk_clk(lnk_clk), .i_lnk_frame(lnk_frame),
    .i_lnk_data(lnk_data), .o_lnk_ready(lnk_ready), .i_rst_req(rst_req), .i_rst_all(rst_all),
    .i_rst_group(rst_group), .o_rst_busy(rst_busy), .o_mirror_reset_line(line), .i_qry_req(qry_req),
    .i_qry_row(qry_row), .i_qry_col(qry_col), .o_qry_valid(qry_valid), .o_qry_q(qry_q),
    .o_cell_complement_output(qry_cmp));
  mmra_ctl_model u_ctl (.o_lnk_clk(lnk_clk), .o_lnk_frame(lnk_frame), .o_lnk_data(lnk_data),
    .i_lnk_ready(lnk_ready));
  // ****************
  // compare and driver tasks
  // ****************
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk16(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic query(input mmra_row_s r);
    @(negedge clk);
    qry_req = 1'b1;
    qry_row = r.row;
    qry_col = r.col;
    @(negedge clk);
    qry_req = 1'b0;
    @(negedge clk);
    chk1("qry_valid", 1'b1, qry_valid);
    chk1("qry_q", r.q, qry_q);
    chk1("qry_cmp", ~r.q, qry_cmp);
  endtask
  task automatic rst_start(input logic [3:0] g);
    int n;
    rst_group = g;
    repeat (4) @(negedge clk);
    rst_req = 1'b1;
    for (n = 0; n < 10 && rst_busy !== 1'b1; n++)
      @(negedge clk);
    rst_req = 1'b0;
    chk1("rst_busy", 1'b1, rst_busy);
  endtask
  task automatic rst_finish(input logic [3:0] g);
    int          n;
    logic [15:0] seen;
    seen = 16'h0000;
    for (n = 0; n < 9000 && rst_busy === 1'b1; n++)
    begin
      @(negedge clk);
      if (line !== 16'h0000)
        seen = line;
    end
    chk16("reset_line", 16'h0001 << g, seen);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************
  // clock, timeout and sequence
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      conclude();
    end
  end
  initial
  begin
    {rst_n, rst_req, rst_all, rst_group, qry_req, qry_row, qry_col} = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    u_ctl.load(32'h0, '{W0, W1, W2, W3});
    repeat (20) @(negedge clk);
    rst_start(4'h0);
    rst_finish(4'h0);
    foreach (cases[i])
      query(cases[i]);
    rst_start(4'h1);
    fork
      u_ctl.load(32'h1, '{~W1, ~W2, ~W3});
    join_none
    // buffer cannot drain during a pulse, so the third word must stall
    repeat (60) @(negedge clk);
    chk1("lnk_ready", 1'b0, lnk_ready);
    rst_finish(4'h1);
    repeat (100) @(negedge clk);
    query(cases[5]);
    rst_start(4'h0);
    rst_finish(4'h0);
    query('{11'h00e, 12'h02e, 1'b0});
    query(cases[0]);
    // an all-array copy outlasts the run, so it is started and then cut by the mid-run reset
    rst_all = 1'b1;
    rst_start(4'h3);
    rst_n = 1'b0;
    @(negedge clk);
    chk1("ready_rst", 1'b1, lnk_ready);
    chk1("busy_rst", 1'b0, rst_busy);
    chk16("line_rst", 16'h0000, line);
    chk1("valid_rst", 1'b0, qry_valid);
    chk1("q_rst", 1'b0, qry_q);
    chk1("cmp_rst", 1'b1, qry_cmp);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk1("busy_rel", 1'b0, rst_busy);
    chk16("line_rel", 16'h0000, line);
    conclude();
  end
endmodule
